// ---- core/ppp_pkg.sv ----
// Operation
// R01 - command and address registers persist across many reads and writes
// R02 - programmer reloads address high byte only when changing 256-entry window
// R03 - chip erase clears program, data and lock; data kept if keep fuse programmed
// R04 - lock bits stay set until program memory erase has finished
// R05 - programmer runs chip erase before reprogramming program or data memory
// R06 - programmer may skip writing all-ones locations after chip erase
// R07 - load strobe rise captures command, address or data per action selects
// R08 - byte select one picks low or high address byte on address load
// R09 - byte select one picks low or high byte of page buffer word
// R10 - data fills page buffer; one write programs the whole page
// R11 - low address bits pick word, upper bits pick page including low-byte top bits
// R12 - erase command: write strobe low starts erase and drops ready
// R13 - write-program command lets address-low and data loads fill page buffer
// R14 - write strobe with byte select one low programs page, ready low until done
// R15 - no-operation command ends page programming and clears write state
// R16 - write-data command fills data buffer, write strobe programs its page
// R17 - read-program command drives low or high byte per byte select one
// R18 - read-data command drives addressed data byte when output enable low
// R19 - fuse write from data low byte; byte selects pick low or high fuses
// R20 - lock write programs zero bits; only chip erase unprograms them
// R21 - fuse/lock read: selects 00 low fuses, 11 high fuses, 01 lock bits
// R22 - signature read picks byte by low address, calibration with select one high
// R23 - action selects 11 or no strobe leave command, address, data unchanged
// R24 - ready flag low during erase or write, high when idle
// R25 - data bus driven only while output enable low
// R26 - write strobes ignored while ready flag is low
package ppp_pkg;
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_PROG = 8'h10;
  localparam logic [7:0] CMD_WR_DATA = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_PROG = 8'h02;
  localparam logic [7:0] CMD_RD_DATA = 8'h03;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] FUSE_LOW_RST = 8'hff;
  localparam logic [7:0] FUSE_HIGH_RST = 8'hff;
  localparam logic [7:0] LOCK_RST = 8'hff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int KEEP_DATA_BIT = 3;
  localparam int CLK_MHZ = 25;
  localparam int PAGE_WRITE_US = 3700;
  localparam int CHIP_ERASE_US = 7500;
  localparam int PAGE_WRITE_CYCLES = PAGE_WRITE_US * CLK_MHZ;
  localparam int CHIP_ERASE_CYCLES = CHIP_ERASE_US * CLK_MHZ;
  localparam int PROG_ADDR_W = 10;
  localparam int PROG_PAGE_W = 4;
  localparam int DATA_ADDR_W = 7;
  localparam int DATA_PAGE_W = 2;
  localparam int FIFO_DEPTH = 16;

  typedef enum {OP_PROG, OP_DATA, OP_FUSE_LO, OP_FUSE_HI, OP_LOCK, OP_ERASE} ppp_op_e;

  typedef struct packed {
    logic to_data;
    logic high;
    logic [7:0] index;
    logic [7:0] value;
  } ppp_entry_s;
endpackage

// ---- core/ppp_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppp_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] count_q;
  logic push, pop;

  assign in_ready = count_q != (AW+1)'(DEPTH);
  assign out_valid = count_q != '0;
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module ppp_port #(
  parameter int unsigned WRITE_CYCLES = ppp_pkg::PAGE_WRITE_CYCLES,
  parameter int unsigned ERASE_CYCLES = ppp_pkg::CHIP_ERASE_CYCLES,
  parameter int FIFO_DEPTH = ppp_pkg::FIFO_DEPTH,
  // identity bytes: values are arbitrary
  parameter logic [7:0] SIG_BYTE0 = 8'h5a,
  parameter logic [7:0] SIG_BYTE1 = 8'h12,
  parameter logic [7:0] SIG_BYTE2 = 8'h34,
  parameter logic [31:0] CAL_BYTES = 32'h80808080
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic LOAD_STROBE_CLOCK,
  input wire logic ACTION_SELECT_HIGH,
  input wire logic ACTION_SELECT_LOW,
  input wire logic BYTE_SELECT_ONE,
  input wire logic BYTE_SELECT_TWO,
  input wire logic WRITE_N,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  output logic READY_BUSY_FLAG
);
  localparam int PAW = ppp_pkg::PROG_ADDR_W;
  localparam int PPW = ppp_pkg::PROG_PAGE_W;
  localparam int DAW = ppp_pkg::DATA_ADDR_W;
  localparam int DPW = ppp_pkg::DATA_PAGE_W;
  localparam int EW = $bits(ppp_pkg::ppp_entry_s);

  typedef enum {ST_IDLE, ST_DRAIN, ST_WAIT, ST_ELOCK} ppp_state_e;
  logic [15:0] prog_q [2**PAW];
  logic [7:0] data_q [2**DAW];
  logic [15:0] pbuf_q [2**PPW];
  logic [7:0] dbuf_q [2**DPW];
  logic [7:0] cmd_q, addr_lo_q, addr_hi_q, data_lo_q;
  logic [7:0] fuse_lo_q, fuse_hi_q, lock_q, out_d;
  logic load_prev_q, write_prev_q, load_rise, write_fall, wait_done, commit;
  ppp_state_e state_q, state_d;
  ppp_pkg::ppp_op_e op_q;
  logic [31:0] cnt_q;
  logic [1:0] action;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready, fifo_push;
  ppp_pkg::ppp_entry_s fifo_in, fifo_out;
  logic [PAW-1:0] prog_addr;
  logic [DAW-1:0] data_addr;

  function automatic logic [PAW-1:0] prog_word(input logic [7:0] hi, input logic [7:0] lo);
    prog_word = PAW'({hi, lo});
  endfunction
  function automatic logic is_write_cmd(input logic [7:0] cmd);
    is_write_cmd = (cmd == ppp_pkg::CMD_WR_PROG) || (cmd == ppp_pkg::CMD_WR_DATA);
  endfunction

  // inputs are synchronous, so edges are taken against the previous sample
  assign load_rise = LOAD_STROBE_CLOCK && !load_prev_q;
  assign write_fall = !WRITE_N && write_prev_q;
  assign action = {ACTION_SELECT_HIGH, ACTION_SELECT_LOW};
  assign prog_addr = prog_word(addr_hi_q, addr_lo_q);
  assign data_addr = DAW'(addr_lo_q);
  assign wait_done = state_q == ST_WAIT && cnt_q == 32'h0;
  assign commit = wait_done;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      load_prev_q <= 1'b0;
      write_prev_q <= 1'b1;
    end else begin
      load_prev_q <= LOAD_STROBE_CLOCK;
      write_prev_q <= WRITE_N;
    end
  end

  // registers change only on a strobe with a loading action
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cmd_q <= ppp_pkg::CMD_RST;
      addr_lo_q <= ppp_pkg::ADDR_RST;
      addr_hi_q <= ppp_pkg::ADDR_RST;
      data_lo_q <= ppp_pkg::ADDR_RST;
    end else if (load_rise) begin // [R23] [R01]
      case (action)
        ppp_pkg::ACT_CMD: cmd_q <= DATA_IN; // [R07]
        ppp_pkg::ACT_ADDR: begin
          if (BYTE_SELECT_ONE) begin // [R08]
            addr_hi_q <= DATA_IN;
          end else begin
            addr_lo_q <= DATA_IN;
          end
        end
        ppp_pkg::ACT_DATA: begin
          if (!BYTE_SELECT_ONE) begin
            data_lo_q <= DATA_IN;
          end
        end
        default: ;
      endcase
    end
  end

  // data bytes are queued so a burst of loads can overlap the drain
  assign fifo_push = load_rise && action == ppp_pkg::ACT_DATA && is_write_cmd(cmd_q); // [R13]
  assign fifo_in = '{to_data: cmd_q == ppp_pkg::CMD_WR_DATA, high: BYTE_SELECT_ONE,
                     index: addr_lo_q, value: DATA_IN};
  // draining stalls during a program cycle, so the queue really fills
  assign fifo_out_ready = state_q == ST_IDLE || state_q == ST_DRAIN;

  ppp_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .reset(RESET),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );

  // page buffers return to erased after a program or data memory commit or a no-operation command
  always_ff @(posedge CLK) begin
    if (RESET || (commit && (op_q == ppp_pkg::OP_PROG || op_q == ppp_pkg::OP_DATA)) ||
        (load_rise && action == ppp_pkg::ACT_CMD && DATA_IN == ppp_pkg::CMD_NOP)) begin // [R15]
      for (int i = 0; i < 2**PPW; i++) begin
        pbuf_q[i] <= {ppp_pkg::ERASED_BYTE, ppp_pkg::ERASED_BYTE};
      end
      for (int i = 0; i < 2**DPW; i++) begin
        dbuf_q[i] <= ppp_pkg::ERASED_BYTE;
      end
    end else if (fifo_out_valid && fifo_out_ready) begin // [R10]
      if (fifo_out.to_data) begin
        dbuf_q[DPW'(fifo_out.index)] <= fifo_out.value; // [R16]
      end else if (fifo_out.high) begin // [R09]
        pbuf_q[PPW'(fifo_out.index)][15:8] <= fifo_out.value;
      end else begin
        pbuf_q[PPW'(fifo_out.index)][7:0] <= fifo_out.value;
      end
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (write_fall && READY_BUSY_FLAG) begin // [R26]
          if (cmd_q == ppp_pkg::CMD_ERASE) begin // [R12]
            state_d = ST_WAIT;
          end else if ((is_write_cmd(cmd_q) && !BYTE_SELECT_ONE) || cmd_q == ppp_pkg::CMD_WR_FUSE ||
                       cmd_q == ppp_pkg::CMD_WR_LOCK) begin // [R14]
            state_d = ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        if (!fifo_out_valid) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wait_done) begin
          state_d = (op_q == ppp_pkg::OP_ERASE) ? ST_ELOCK : ST_IDLE;
        end
      end
      ST_ELOCK: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_q <= ST_IDLE;
      op_q <= ppp_pkg::OP_PROG;
      cnt_q <= 32'h0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_IDLE && state_d != ST_IDLE) begin
        if (cmd_q == ppp_pkg::CMD_ERASE) begin
          op_q <= ppp_pkg::OP_ERASE;
          cnt_q <= ERASE_CYCLES - 1;
        end else begin
          cnt_q <= WRITE_CYCLES - 1;
          case (cmd_q)
            ppp_pkg::CMD_WR_PROG: op_q <= ppp_pkg::OP_PROG;
            ppp_pkg::CMD_WR_DATA: op_q <= ppp_pkg::OP_DATA;
            ppp_pkg::CMD_WR_LOCK: op_q <= ppp_pkg::OP_LOCK;
            default: op_q <= BYTE_SELECT_ONE ? ppp_pkg::OP_FUSE_HI : ppp_pkg::OP_FUSE_LO; // [R19]
          endcase
        end
      end else if (state_q == ST_WAIT && cnt_q != 32'h0) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end

  // the arrays model nonvolatile cells, so they carry no reset
  always_ff @(posedge CLK) begin
    if (commit && op_q == ppp_pkg::OP_ERASE) begin // [R03]
      for (int i = 0; i < 2**PAW; i++) begin
        prog_q[i] <= {ppp_pkg::ERASED_BYTE, ppp_pkg::ERASED_BYTE};
      end
    end else if (commit && op_q == ppp_pkg::OP_PROG) begin // [R11]
      for (int i = 0; i < 2**PPW; i++) begin
        prog_q[{prog_addr[PAW-1:PPW], PPW'(i)}] <= pbuf_q[i];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (commit && op_q == ppp_pkg::OP_ERASE) begin
      if (fuse_hi_q[ppp_pkg::KEEP_DATA_BIT]) begin // [R03]
        for (int i = 0; i < 2**DAW; i++) begin
          data_q[i] <= ppp_pkg::ERASED_BYTE;
        end
      end
    end else if (commit && op_q == ppp_pkg::OP_DATA) begin
      for (int i = 0; i < 2**DPW; i++) begin
        data_q[{data_addr[DAW-1:DPW], DPW'(i)}] <= dbuf_q[i];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      fuse_lo_q <= ppp_pkg::FUSE_LOW_RST;
      fuse_hi_q <= ppp_pkg::FUSE_HIGH_RST;
      lock_q <= ppp_pkg::LOCK_RST;
    end else if (state_q == ST_ELOCK) begin // [R04]
      lock_q <= ppp_pkg::LOCK_RST;
    end else if (commit) begin
      case (op_q)
        ppp_pkg::OP_FUSE_LO: fuse_lo_q <= data_lo_q; // [R19]
        ppp_pkg::OP_FUSE_HI: fuse_hi_q <= data_lo_q;
        ppp_pkg::OP_LOCK: lock_q <= lock_q & data_lo_q; // [R20]
        default: ;
      endcase
    end
  end

  always_comb begin
    out_d = 8'h00;
    case (cmd_q)
      ppp_pkg::CMD_RD_PROG: out_d = BYTE_SELECT_ONE ? prog_q[prog_addr][15:8] : prog_q[prog_addr][7:0]; // [R17]
      ppp_pkg::CMD_RD_DATA: out_d = data_q[data_addr]; // [R18]
      ppp_pkg::CMD_RD_FUSE: begin // [R21]
        case ({BYTE_SELECT_TWO, BYTE_SELECT_ONE})
          2'h0: out_d = fuse_lo_q;
          2'h3: out_d = fuse_hi_q;
          2'h1: out_d = lock_q;
          default: out_d = ppp_pkg::ERASED_BYTE;
        endcase
      end
      ppp_pkg::CMD_RD_SIG: begin // [R22]
        if (BYTE_SELECT_ONE) begin
          out_d = CAL_BYTES[8*addr_lo_q[1:0] +: 8];
        end else begin
          case (addr_lo_q[1:0])
            2'h0: out_d = SIG_BYTE0;
            2'h1: out_d = SIG_BYTE1;
            2'h2: out_d = SIG_BYTE2;
            default: out_d = ppp_pkg::ERASED_BYTE;
          endcase
        end
      end
      default: out_d = 8'h00;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      DATA_OUT <= 8'h00;
      DATA_OE <= 1'b0;
    end else begin
      DATA_OUT <= out_d;
      DATA_OE <= !OUTPUT_ENABLE_N; // [R25]
    end
  end

  // a full queue also reads as busy so the programmer holds off
  always_ff @(posedge CLK) begin
    if (RESET) begin
      READY_BUSY_FLAG <= 1'b1;
    end else begin
      READY_BUSY_FLAG <= state_d == ST_IDLE && fifo_in_ready; // [R24]
    end
  end

  sequence s_write_start;
    write_fall && READY_BUSY_FLAG && state_q == ST_IDLE && !BYTE_SELECT_ONE && is_write_cmd(cmd_q);
  endsequence
  sequence s_busy_two;
    !READY_BUSY_FLAG [*2];
  endsequence

  a_cmd_capture: assert property (@(posedge CLK) disable iff (RESET) // [R07]
    load_rise && action == ppp_pkg::ACT_CMD |=> cmd_q == $past(DATA_IN)) else $error("command not captured");
  a_addr_route: assert property (@(posedge CLK) disable iff (RESET) // [R08]
    load_rise && action == ppp_pkg::ACT_ADDR && BYTE_SELECT_ONE |=> addr_hi_q == $past(DATA_IN) && $stable(addr_lo_q))
    else $error("address byte misrouted");
  a_regs_hold: assert property (@(posedge CLK) disable iff (RESET) // [R23]
    !load_rise || action == 2'h3 |=> $stable(cmd_q) && $stable(addr_lo_q) && $stable(addr_hi_q))
    else $error("registers changed without load");
  a_page_busy: assert property (@(posedge CLK) disable iff (RESET) // [R14]
    s_write_start |=> s_busy_two) else $error("page write did not drop ready");
  a_erase_busy: assert property (@(posedge CLK) disable iff (RESET) // [R12]
    write_fall && READY_BUSY_FLAG && state_q == ST_IDLE && cmd_q == ppp_pkg::CMD_ERASE |=> state_q == ST_WAIT ##0
    !READY_BUSY_FLAG) else $error("erase did not start");
  a_ready_idle: assert property (@(posedge CLK) disable iff (RESET) // [R24]
    READY_BUSY_FLAG |-> state_q == ST_IDLE) else $error("ready while busy");
  a_lock_order: assert property (@(posedge CLK) disable iff (RESET) // [R04]
    commit && op_q == ppp_pkg::OP_ERASE |=> $stable(lock_q) ##1 lock_q == ppp_pkg::LOCK_RST)
    else $error("lock bits cleared out of order");
  a_lock_onlyset: assert property (@(posedge CLK) disable iff (RESET) // [R20]
    (lock_q & ~$past(lock_q)) != 8'h00 |-> $past(state_q) == ST_ELOCK) else $error("lock bit unprogrammed");
  a_bus_drive: assert property (@(posedge CLK) disable iff (RESET) // [R25]
    DATA_OE |-> !$past(OUTPUT_ENABLE_N)) else $error("bus driven without output enable");
  a_write_ignored: assert property (@(posedge CLK) disable iff (RESET) // [R26]
    write_fall && state_q == ST_WAIT && !wait_done |=> state_q == ST_WAIT && cnt_q == $past(cnt_q) - 32'h1)
    else $error("write disturbed busy cycle");
endmodule
`default_nettype wire

// ---- verif/ppp_prog_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppp_prog_model (
  input wire logic clk,
  input wire logic ready,
  input wire logic dev_oe,
  input wire logic [7:0] bus,
  output logic strobe,
  output logic act_hi,
  output logic act_lo,
  output logic bs1,
  output logic bs2,
  output logic wr_n,
  output logic oe_n,
  output logic [7:0] drive
);
  initial begin
    strobe = 1'b0;
    act_hi = 1'b1;
    act_lo = 1'b1;
    bs1 = 1'b0;
    bs2 = 1'b0;
    wr_n = 1'b1;
    oe_n = 1'b1;
    drive = 8'h00;
  end

  // no load while busy: a full queue would drop the byte
  task automatic load(input logic [1:0] act, input logic sel, input logic [7:0] d);
    #1;
    while (ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    {act_hi, act_lo} <= act;
    bs1 <= sel;
    drive <= d;
    strobe <= 1'b1;
    @(posedge clk);
    strobe <= 1'b0;
    @(posedge clk);
    {act_hi, act_lo} <= 2'h3;
    drive <= ~d; // released bus must not look held
  endtask

  task automatic write_pulse(input logic sel, input logic sel2);
    @(posedge clk);
    bs1 <= sel;
    bs2 <= sel2;
    wr_n <= 1'b0;
    repeat (2) @(posedge clk);
    wr_n <= 1'b1;
  endtask

  task automatic read(input logic sel2, input logic sel, output logic [7:0] d, output logic en);
    @(posedge clk);
    bs1 <= sel;
    bs2 <= sel2;
    oe_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    d = bus;
    en = dev_oe;
    @(posedge clk);
    oe_n <= 1'b1;
    bs2 <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verif/parallel_program_port_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module parallel_program_port_bench;
  localparam int WC = 20;
  localparam int EC = 40;
  // arbitrary identity values
  localparam logic [7:0] SIG0 = 8'h6b;
  localparam logic [7:0] SIG1 = 8'h2c;
  localparam logic [7:0] SIG2 = 8'h4d;
  localparam logic [31:0] CAL = 32'h9b7a5c3e;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic strobe, ahi, alo, bs1, bs2, wr_n, oe_n, oe, rdy, en;
  logic [7:0] drive, dout, bus, v;
  logic [7:0] pw [32];
  logic [7:0] ew [4];
  logic [7:0] sig [3];
  int fail_count = 0;
  int total_checks = 0;
  int last_wait = 0;

  always #20 clk = ~clk;
  assign bus = oe ? dout : drive;

  ppp_port #(.WRITE_CYCLES(WC), .ERASE_CYCLES(EC), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2),
    .CAL_BYTES(CAL)) dut (.CLK(clk), .RESET(reset), .LOAD_STROBE_CLOCK(strobe), .ACTION_SELECT_HIGH(ahi),
    .ACTION_SELECT_LOW(alo), .BYTE_SELECT_ONE(bs1), .BYTE_SELECT_TWO(bs2), .WRITE_N(wr_n),
    .OUTPUT_ENABLE_N(oe_n), .DATA_IN(bus), .DATA_OUT(dout), .DATA_OE(oe), .READY_BUSY_FLAG(rdy));
  ppp_prog_model prog (.clk(clk), .ready(rdy), .dev_oe(oe), .bus(bus), .strobe(strobe), .act_hi(ahi),
    .act_lo(alo), .bs1(bs1), .bs2(bs2), .wr_n(wr_n), .oe_n(oe_n), .drive(drive));

  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // lock bits only ever move towards programmed
  function automatic logic [7:0] lock_after(input logic [7:0] old, input logic [7:0] d);
    return old & d;
  endfunction

  task automatic op(input logic sel, input logic sel2);
    int n;
    n = 0;
    prog.write_pulse(sel, sel2);
    @(posedge clk);
    #1;
    `CHK(rdy, 1'b0);
    while (rdy !== 1'b1 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    last_wait = n;
    `CHK(rdy, 1'b1);
  endtask

  task automatic rd(input logic sel2, input logic sel, input logic [7:0] e);
    prog.read(sel2, sel, v, en);
    `CHK(en, 1'b1);
    `CHK(v, e);
  endtask

  task automatic cmd(input logic [7:0] c);
    prog.load(ppp_pkg::ACT_CMD, 1'b0, c);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end

  initial begin
    void'($urandom(32'he5fc));
    sig[0] = SIG0;
    sig[1] = SIG1;
    sig[2] = SIG2;
    for (int i = 0; i < 32; i++)
      pw[i] = 8'($urandom);
    pw[0] = 8'h00;
    // an all-ones word that the load loop skips
    pw[2] = 8'hff;
    pw[3] = 8'hff;
    for (int i = 0; i < 4; i++)
      ew[i] = 8'($urandom);
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(rdy, 1'b1);
    `CHK(oe, 1'b0);
    cmd(ppp_pkg::CMD_ERASE);
    op(1'b0, 1'b0);
    cmd(ppp_pkg::CMD_WR_PROG);
    prog.load(ppp_pkg::ACT_ADDR, 1'b1, 8'h01);
    for (int i = 0; i < 16; i++) begin
      prog.load(ppp_pkg::ACT_ADDR, 1'b0, 8'h30 | 8'(i));
      if (pw[2*i] != 8'hff || pw[2*i+1] != 8'hff) begin
        prog.load(ppp_pkg::ACT_DATA, 1'b0, pw[2*i]);
        prog.load(ppp_pkg::ACT_DATA, 1'b1, pw[2*i+1]);
      end
    end
    op(1'b0, 1'b0);
    cmd(ppp_pkg::CMD_NOP);
    cmd(ppp_pkg::CMD_RD_PROG);
    for (int i = 0; i < 16; i++) begin
      prog.load(ppp_pkg::ACT_ADDR, 1'b0, 8'h30 | 8'(i));
      rd(1'b0, 1'b0, pw[2*i]);
      rd(1'b0, 1'b1, pw[2*i+1]);
    end
    prog.load(2'h3, 1'b0, 8'h20);
    rd(1'b0, 1'b1, pw[31]);
    prog.load(ppp_pkg::ACT_ADDR, 1'b0, 8'h20);
    rd(1'b0, 1'b0, 8'hff);
    cmd(ppp_pkg::CMD_WR_DATA);
    for (int i = 0; i < 4; i++) begin
      prog.load(ppp_pkg::ACT_ADDR, 1'b0, 8'h44 | 8'(i));
      prog.load(ppp_pkg::ACT_DATA, 1'b0, ew[i]);
    end
    op(1'b0, 1'b0);
    cmd(ppp_pkg::CMD_RD_DATA);
    for (int i = 0; i < 4; i++) begin
      prog.load(ppp_pkg::ACT_ADDR, 1'b0, 8'h44 | 8'(i));
      rd(1'b0, 1'b0, ew[i]);
    end
    cmd(ppp_pkg::CMD_WR_FUSE);
    prog.load(ppp_pkg::ACT_DATA, 1'b0, 8'ha5);
    op(1'b0, 1'b0);
    prog.load(ppp_pkg::ACT_DATA, 1'b0, 8'hf7);
    op(1'b1, 1'b0);
    cmd(ppp_pkg::CMD_WR_LOCK);
    prog.load(ppp_pkg::ACT_DATA, 1'b0, 8'hfc);
    op(1'b0, 1'b0);
    prog.load(ppp_pkg::ACT_DATA, 1'b0, 8'hff);
    prog.write_pulse(1'b0, 1'b0);
    // the pulse inside op lands while busy and must not restart the cycle
    op(1'b0, 1'b0);
    `CHK(last_wait < WC - 1, 1'b1);
    cmd(ppp_pkg::CMD_RD_FUSE);
    rd(1'b0, 1'b0, 8'ha5);
    rd(1'b1, 1'b1, 8'hf7);
    rd(1'b0, 1'b1, lock_after(lock_after(8'hff, 8'hfc), 8'hff));
    rd(1'b1, 1'b0, 8'hff);
    cmd(ppp_pkg::CMD_ERASE);
    op(1'b0, 1'b0);
    cmd(ppp_pkg::CMD_RD_FUSE);
    rd(1'b0, 1'b1, 8'hff);
    rd(1'b0, 1'b0, 8'ha5);
    cmd(ppp_pkg::CMD_RD_PROG);
    prog.load(ppp_pkg::ACT_ADDR, 1'b0, 8'h3f);
    rd(1'b0, 1'b1, 8'hff);
    cmd(ppp_pkg::CMD_RD_DATA);
    prog.load(ppp_pkg::ACT_ADDR, 1'b0, 8'h44);
    rd(1'b0, 1'b0, ew[0]);
    cmd(ppp_pkg::CMD_RD_SIG);
    prog.load(ppp_pkg::ACT_ADDR, 1'b1, 8'h00);
    for (int i = 0; i < 3; i++) begin
      prog.load(ppp_pkg::ACT_ADDR, 1'b0, 8'(i));
      rd(1'b0, 1'b0, sig[i]);
      rd(1'b0, 1'b1, CAL[8*i +: 8]);
    end
    prog.load(ppp_pkg::ACT_ADDR, 1'b0, 8'h03);
    rd(1'b0, 1'b0, 8'hff);
    repeat (2) @(posedge clk);
    #1;
    `CHK(oe, 1'b0);
    conclude();
  end
endmodule
`undef CHK
`default_nettype wire
